// File: hdl/wsf_pkg.sv
// Shared constants for the sublayer payload framer
package wsf_pkg;

  // Word and counter widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned COL_W = 14;
  localparam int unsigned ROW_W = 4;
  localparam int unsigned SCR_W = 7;

  // Frame geometry in 16-bit words per row
  localparam int unsigned TOH_WORDS = 288;   // Section and line overhead
  localparam int unsigned POH_WORDS = 32;    // Path overhead plus fixed stuff
  localparam int unsigned PAY_WORDS = 8320;  // Payload capacity
  localparam logic [3:0] ROW_LAST = 4'h8;    // Nine rows, 0 to 8

  // Rows that carry special overhead
  localparam logic [3:0] PTR_ROW = 4'h3;     // Pointer octets
  localparam logic [3:0] C2_ROW = 4'h2;      // Signal label row of path column
  localparam logic [3:0] S1_ROW = 4'h8;      // Sync status row

  // Overhead codings
  localparam logic [15:0] A1_PAIR = 16'hf6f6;
  localparam logic [15:0] A2_PAIR = 16'h2828;
  localparam logic [7:0] H1_FIRST = 8'h6a;   // New-data off, pointer high bits
  localparam logic [7:0] H1_CONC = 8'h93;    // Concatenation indication
  localparam logic [7:0] H2_FIRST = 8'h0a;   // Pointer low bits
  localparam logic [7:0] H2_CONC = 8'hff;
  localparam logic [9:0] PTR_VALUE = 10'h20a; // Constant pointer 522
  localparam logic [7:0] C2_LABEL = 8'h1a;
  localparam logic [7:0] S1_CODE = 8'h0f;
  localparam logic [7:0] J1_HEADER = 8'h89;  // Default trace header octet
  localparam logic [7:0] ZERO_OCTET = 8'h00;
  localparam logic [3:0] TRACE_LAST = 4'hf;  // Sixteen-octet trace

  // Receive supervision thresholds
  localparam logic [2:0] LOF_MISSES = 3'h4;  // Missed patterns to lose frame
  localparam logic [1:0] LOP_FRAMES = 2'h3;  // Bad pointers to lose pointer

  // Scrambler seed, loaded at the end of row-0 overhead
  localparam logic [6:0] SCR_SEED = 7'h7f;

  // Receive frame search states
  typedef enum logic [1:0] {
    WSF_HUNT,
    WSF_PRESYNC,
    WSF_SYNC
  } wsf_sync_e;

endpackage

// File: hdl/wsf_scrambler.sv
`timescale 1ns/1ps
`default_nettype none
// Frame-synchronous x^7+x^6+1 key generator, 16 key bits per word
module wsf_scrambler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  output logic [15:0] key
);

  logic [6:0] state_r;  // Generator state
  logic [6:0] state_nxt;

  // Key for this word, first-sent bit in bit 15
  always_comb begin
    logic [6:0] s;
    s = state_r;
    key = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      key[15 - i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    // Reload seed so the next word starts a fresh sequence
    state_nxt = load ? wsf_pkg::SCR_SEED : s;
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= wsf_pkg::SCR_SEED;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule // wsf_scrambler
`default_nettype wire

// File: hdl/wsf_framer.sv
`timescale 1ns/1ps
`default_nettype none
module wsf_framer #(
  parameter int unsigned TOH_W = wsf_pkg::TOH_WORDS,
  parameter int unsigned POH_W = wsf_pkg::POH_WORDS,
  parameter int unsigned PAY_W = wsf_pkg::PAY_WORDS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic [15:0] tx_word,
  input wire logic tx_word_valid,
  output logic tx_word_ready,
  output logic [15:0] tx_group,
  output logic tx_underrun,
  input wire logic [15:0] rx_group,
  output logic [15:0] rx_word,
  output logic rx_word_valid,
  output logic link_health_indication,
  output logic loss_of_frame,
  output logic loss_of_pointer,
  output logic label_mismatch
);

  // Column landmarks within a row
  localparam logic [13:0] A2_COL = 14'(TOH_W / 3);      // First A2 word
  localparam logic [13:0] J0_COL = 14'(2 * (TOH_W / 3)); // End of A2 words
  localparam logic [13:0] SPE_COL = 14'(TOH_W);         // Path column
  localparam logic [13:0] PAY_COL = 14'(TOH_W + POH_W); // First payload
  localparam logic [13:0] ROW_END = 14'(TOH_W + POH_W + PAY_W - 1);
  localparam logic [13:0] SCR_LOAD = 14'(TOH_W - 1);    // Seed point
  localparam logic [13:0] COL_ZERO = 14'h0000;
  localparam logic [13:0] COL_ONE = 14'h0001;
  localparam logic [3:0] ROW_ZERO = 4'h0;

  // ---------------- Transmit path ----------------

  logic [13:0] tx_col_r, tx_col_nxt;     // Word column
  logic [3:0] tx_row_r, tx_row_nxt;      // Row of frame
  logic [3:0] trace_r, trace_nxt;        // Path trace octet index
  logic [15:0] tx_group_r, tx_group_nxt; // Registered group to PMA
  logic tx_under_r, tx_under_nxt;        // Payload slot with no word
  logic [15:0] tx_key;                   // Scrambler key
  logic tx_scr_load;                     // Seed at row-0 overhead end
  logic [15:0] tx_raw;                   // Unscrambled frame word
  logic [7:0] tx_poh;                    // Path overhead octet
  logic tx_pay;                          // Current slot is payload
  logic tx_scr_on;                       // Current slot is scrambled

  // Transmit key generator
  wsf_scrambler u_tx_scr (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(tx_scr_load),
    .key(tx_key)
  );

  // Transmit frame builder
  always_comb begin
    tx_pay = (tx_col_r >= PAY_COL);
    // Ready only in payload slots; overhead stalls the source
    tx_word_ready = tx_pay && tx_enable;
    tx_scr_load = (tx_row_r == ROW_ZERO) && (tx_col_r == SCR_LOAD);
    tx_scr_on = (tx_row_r != ROW_ZERO) || (tx_col_r >= SPE_COL);
    // Path overhead octet by row
    if (tx_row_r == ROW_ZERO) begin
      tx_poh = (trace_r == 4'h0) ? wsf_pkg::J1_HEADER : wsf_pkg::ZERO_OCTET;
    end else if (tx_row_r == wsf_pkg::C2_ROW) begin
      tx_poh = wsf_pkg::C2_LABEL;
    end else begin
      tx_poh = wsf_pkg::ZERO_OCTET;
    end
    tx_under_nxt = 1'b0;
    // Overhead octets are placed MSB first as-is
    if (tx_row_r == ROW_ZERO && tx_col_r < A2_COL) begin
      tx_raw = wsf_pkg::A1_PAIR;
    end else if (tx_row_r == ROW_ZERO && tx_col_r < J0_COL) begin
      tx_raw = wsf_pkg::A2_PAIR;
    end else if (tx_row_r == wsf_pkg::PTR_ROW && tx_col_r == COL_ZERO) begin
      tx_raw = {wsf_pkg::H1_FIRST, wsf_pkg::H1_CONC};
    end else if (tx_row_r == wsf_pkg::PTR_ROW && tx_col_r < A2_COL) begin
      tx_raw = {wsf_pkg::H1_CONC, wsf_pkg::H1_CONC};
    end else if (tx_row_r == wsf_pkg::PTR_ROW && tx_col_r == A2_COL) begin
      tx_raw = {wsf_pkg::H2_FIRST, wsf_pkg::H2_CONC};
    end else if (tx_row_r == wsf_pkg::PTR_ROW && tx_col_r < J0_COL) begin
      tx_raw = {wsf_pkg::H2_CONC, wsf_pkg::H2_CONC};
    end else if (tx_row_r == wsf_pkg::S1_ROW && tx_col_r == COL_ZERO) begin
      tx_raw = {wsf_pkg::S1_CODE, wsf_pkg::ZERO_OCTET};
    end else if (tx_col_r < SPE_COL) begin
      // Other section and line overhead is zero
      tx_raw = 16'h0000;
    end else if (tx_col_r == SPE_COL) begin
      // Path octet, then first stuff octet
      tx_raw = {tx_poh, wsf_pkg::ZERO_OCTET};
    end else if (!tx_pay) begin
      // Fixed stuff
      tx_raw = 16'h0000;
    end else if (tx_word_valid && tx_enable) begin
      // Full reversal: word bit 0 lands in first-sent bit 15,
      // low byte in the even (first) octet, high byte in the odd one
      tx_raw = {<<{tx_word}};
    end else begin
      // Source starved: send zero payload, flag it
      tx_raw = 16'h0000;
      tx_under_nxt = tx_enable;
    end
    tx_group_nxt = tx_raw ^ (tx_scr_on ? tx_key : 16'h0000);
    // Position counters, rows and frames run without gaps
    tx_col_nxt = tx_col_r + COL_ONE;
    tx_row_nxt = tx_row_r;
    trace_nxt = trace_r;
    if (tx_col_r == ROW_END) begin
      tx_col_nxt = COL_ZERO;
      if (tx_row_r == wsf_pkg::ROW_LAST) begin
        tx_row_nxt = ROW_ZERO;
        trace_nxt = (trace_r == wsf_pkg::TRACE_LAST) ? 4'h0 : trace_r + 4'h1;
      end else begin
        tx_row_nxt = tx_row_r + 4'h1;
      end
    end
  end

  // Transmit registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_col_r <= COL_ZERO;
      tx_row_r <= ROW_ZERO;
      trace_r <= 4'h0;
      tx_group_r <= 16'h0000;
      tx_under_r <= 1'b0;
    end else begin
      tx_col_r <= tx_col_nxt;
      tx_row_r <= tx_row_nxt;
      trace_r <= trace_nxt;
      tx_group_r <= tx_group_nxt;
      tx_under_r <= tx_under_nxt;
    end
  end

  assign tx_group = tx_group_r;
  assign tx_underrun = tx_under_r;

  // ---------------- Receive path ----------------

  logic [15:0] w1_r, w1_nxt;             // Previous group
  logic [15:0] w2_r, w2_nxt;             // Group before that
  logic [3:0] shift_r, shift_nxt;        // Bit offset of octet boundary
  wsf_pkg::wsf_sync_e st_r, st_nxt;      // Frame search state
  logic [2:0] miss_r, miss_nxt;          // Consecutive pattern misses
  logic [13:0] rx_col_r, rx_col_nxt;     // Word column
  logic [3:0] rx_row_r, rx_row_nxt;      // Row of frame
  logic [7:0] h1_r, h1_nxt;              // Captured first pointer octet
  logic [1:0] lop_cnt_r, lop_cnt_nxt;    // Bad pointer frames
  logic lop_r, lop_nxt;                  // Loss of pointer
  logic c2_bad_r, c2_bad_nxt;            // Label mismatch
  logic lof_r, lof_nxt;                  // Loss of frame
  logic health_r, health_nxt;            // Health towards PCS
  logic [15:0] rx_word_r, rx_word_nxt;   // Word to PCS
  logic rx_valid_r, rx_valid_nxt;        // Word strobe
  logic [47:0] cat;                      // Three-group window
  logic [15:0] aw;                       // Aligned word
  logic [15:0] prev_aw;                  // Aligned word before it
  logic [15:0] rx_key;                   // Descrambler key
  logic [15:0] d;                        // Descrambled word
  logic rx_scr_load;
  logic found;                           // Pattern seen while hunting
  logic [3:0] found_shift;
  logic [9:0] ptr;                       // Received pointer value

  // Receive key generator
  wsf_scrambler u_rx_scr (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(rx_scr_load),
    .key(rx_key)
  );

  // Alignment, framing and overhead processing
  always_comb begin
    cat = {w2_r, w1_r, rx_group};
    w1_nxt = rx_group;
    w2_nxt = w1_r;
    aw = cat[(31 - int'(shift_r)) -: 16];
    prev_aw = cat[(47 - int'(shift_r)) -: 16];
    // Search every bit offset for the A1/A2 boundary
    found = 1'b0;
    found_shift = 4'h0;
    for (int s = 0; s < 16; s++) begin
      if (!found && cat[(47 - s) -: 32] ==
          {wsf_pkg::A1_PAIR, wsf_pkg::A2_PAIR}) begin
        found = 1'b1;
        found_shift = 4'(s);
      end
    end
    rx_scr_load = (rx_row_r == ROW_ZERO) && (rx_col_r == SCR_LOAD);
    if (rx_row_r != ROW_ZERO || rx_col_r >= SPE_COL) begin
      d = aw ^ rx_key;
    end else begin
      d = aw;
    end
    ptr = {h1_r[1:0], d[15:8]};
    // Defaults hold state
    shift_nxt = shift_r;
    st_nxt = st_r;
    miss_nxt = miss_r;
    h1_nxt = h1_r;
    lop_cnt_nxt = lop_cnt_r;
    lop_nxt = lop_r;
    c2_bad_nxt = c2_bad_r;
    rx_word_nxt = rx_word_r;
    rx_valid_nxt = 1'b0;
    // Position advance
    rx_col_nxt = rx_col_r + COL_ONE;
    rx_row_nxt = rx_row_r;
    if (rx_col_r == ROW_END) begin
      rx_col_nxt = COL_ZERO;
      rx_row_nxt = (rx_row_r == wsf_pkg::ROW_LAST) ? ROW_ZERO
                                                   : rx_row_r + 4'h1;
    end
    case (st_r)
      wsf_pkg::WSF_HUNT: begin
        // Lock offset; this word is the first A2 word
        if (found) begin
          shift_nxt = found_shift;
          rx_col_nxt = A2_COL + COL_ONE;
          rx_row_nxt = ROW_ZERO;
          miss_nxt = 3'h0;
          st_nxt = wsf_pkg::WSF_PRESYNC;
        end
      end
      wsf_pkg::WSF_PRESYNC: begin
        // One confirmation one frame later
        if (rx_row_r == ROW_ZERO && rx_col_r == A2_COL) begin
          if (prev_aw == wsf_pkg::A1_PAIR && aw == wsf_pkg::A2_PAIR) begin
            st_nxt = wsf_pkg::WSF_SYNC;
          end else begin
            st_nxt = wsf_pkg::WSF_HUNT;
          end
        end
      end
      wsf_pkg::WSF_SYNC: begin
        // Count consecutive misses of the framing pattern
        if (rx_row_r == ROW_ZERO && rx_col_r == A2_COL) begin
          if (prev_aw == wsf_pkg::A1_PAIR && aw == wsf_pkg::A2_PAIR) begin
            miss_nxt = 3'h0;
          end else if (miss_r + 3'h1 == wsf_pkg::LOF_MISSES) begin
            st_nxt = wsf_pkg::WSF_HUNT;
            miss_nxt = 3'h0;
          end else begin
            miss_nxt = miss_r + 3'h1;
          end
        end
      end
      default: begin
        st_nxt = wsf_pkg::WSF_HUNT;
      end
    endcase
    if (st_r != wsf_pkg::WSF_HUNT) begin
      // Pointer octets from line overhead
      if (rx_row_r == wsf_pkg::PTR_ROW && rx_col_r == COL_ZERO) begin
        h1_nxt = d[15:8];
      end
      if (rx_row_r == wsf_pkg::PTR_ROW && rx_col_r == A2_COL) begin
        if (ptr == wsf_pkg::PTR_VALUE) begin
          lop_cnt_nxt = 2'h0;
          lop_nxt = 1'b0;
        end else if (lop_cnt_r + 2'h1 == wsf_pkg::LOP_FRAMES) begin
          lop_nxt = 1'b1;
        end else begin
          lop_cnt_nxt = lop_cnt_r + 2'h1;
        end
      end
      // Path column: signal label check
      if (rx_row_r == wsf_pkg::C2_ROW && rx_col_r == SPE_COL) begin
        c2_bad_nxt = (d[15:8] != wsf_pkg::C2_LABEL);
      end
      // Payload only; stuff and path columns fall through
      if (rx_col_r >= PAY_COL && st_r == wsf_pkg::WSF_SYNC &&
          rx_enable) begin
        // First-received bit to word bit 0, even octet to low byte
        rx_word_nxt = {<<{d}};
        rx_valid_nxt = 1'b1;
      end
    end
    lof_nxt = (st_nxt != wsf_pkg::WSF_SYNC);
    // Frame loss, pointer loss or disabled receiver reads as fail
    health_nxt = !lof_nxt && !lop_nxt && rx_enable;
  end

  // Receive registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      w1_r <= 16'h0000;
      w2_r <= 16'h0000;
      shift_r <= 4'h0;
      st_r <= wsf_pkg::WSF_HUNT;
      miss_r <= 3'h0;
      rx_col_r <= COL_ZERO;
      rx_row_r <= ROW_ZERO;
      h1_r <= 8'h00;
      lop_cnt_r <= 2'h0;
      lop_r <= 1'b0;
      c2_bad_r <= 1'b0;
      lof_r <= 1'b1;
      health_r <= 1'b0;
      rx_word_r <= 16'h0000;
      rx_valid_r <= 1'b0;
    end else begin
      w1_r <= w1_nxt;
      w2_r <= w2_nxt;
      shift_r <= shift_nxt;
      st_r <= st_nxt;
      miss_r <= miss_nxt;
      rx_col_r <= rx_col_nxt;
      rx_row_r <= rx_row_nxt;
      h1_r <= h1_nxt;
      lop_cnt_r <= lop_cnt_nxt;
      lop_r <= lop_nxt;
      c2_bad_r <= c2_bad_nxt;
      lof_r <= lof_nxt;
      health_r <= health_nxt;
      rx_word_r <= rx_word_nxt;
      rx_valid_r <= rx_valid_nxt;
    end
  end

  // Status and data outputs, all from flip-flops
  assign rx_word = rx_word_r;
  assign rx_word_valid = rx_valid_r;
  assign link_health_indication = health_r;
  assign loss_of_frame = lof_r;
  assign loss_of_pointer = lop_r;
  assign label_mismatch = c2_bad_r;

endmodule // wsf_framer
`default_nettype wire

// File: sim/wsf_framer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks of the payload framer
module wsf_framer_chk #(
  parameter int unsigned PAY_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_word_valid,
  input wire logic tx_word_ready,
  input wire logic tx_underrun,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic link_health_indication,
  input wire logic loss_of_frame,
  input wire logic loss_of_pointer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] run_r; // Length of current ready run
  logic dirty_r; // Run cut by transmit disable
  // Ready run length and disable tracking
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 16'h0;
      dirty_r <= 1'b1;
    end else begin
      run_r <= tx_word_ready ? run_r + 16'h1 : 16'h0;
      dirty_r <= !tx_enable | (dirty_r & tx_word_ready);
    end
  end
  chk_ready_gated: assert property (
    !tx_enable |-> !tx_word_ready) else $error("ready while disabled");
  chk_underrun_slot: assert property (
    tx_word_ready && !tx_word_valid |=> tx_underrun)
    else $error("empty slot without underrun");
  chk_underrun_only: assert property (
    tx_underrun |-> $past(tx_word_ready && !tx_word_valid))
    else $error("underrun without empty slot");
  chk_run_length: assert property (
    $fell(tx_word_ready) && tx_enable && !dirty_r |-> run_r == PAY_W)
    else $error("payload run length wrong");
  chk_health_lof: assert property (
    $rose(loss_of_frame) |-> ##[0:1] !link_health_indication)
    else $error("health ok after frame loss");
  chk_health_lop: assert property (
    loss_of_pointer ##1 loss_of_pointer |-> !link_health_indication)
    else $error("health ok after pointer loss");
  chk_health_rxoff: assert property (
    !rx_enable ##1 !rx_enable |-> !link_health_indication)
    else $error("health ok while receive off");
  chk_rx_gated: assert property (
    !rx_enable ##1 !rx_enable |-> !rx_word_valid)
    else $error("word while receive off");
  chk_rx_nosync: assert property (
    loss_of_frame ##1 loss_of_frame |-> !rx_word_valid)
    else $error("word without frame sync");
  chk_rx_hold: assert property (
    !rx_word_valid |-> $stable(rx_word)) else $error("word moved");
  // Main scenarios reached
  cov_underrun: cover property (tx_underrun);
  cov_sync: cover property ($fell(loss_of_frame));
  cov_lof: cover property ($rose(loss_of_frame));
  cov_word: cover property (rx_word_valid && link_health_indication);
endmodule // wsf_framer_chk

bind wsf_framer wsf_framer_chk #(.PAY_W(PAY_W)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .tx_enable(tx_enable),
  .rx_enable(rx_enable), .tx_word_valid(tx_word_valid),
  .tx_word_ready(tx_word_ready), .tx_underrun(tx_underrun),
  .rx_word(rx_word), .rx_word_valid(rx_word_valid),
  .link_health_indication(link_health_indication),
  .loss_of_frame(loss_of_frame), .loss_of_pointer(loss_of_pointer));
`default_nettype wire

// File: sim/wsf_pcs_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural PCS: counting word source and checking sink
module wsf_pcs_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic stall,
  input wire logic clr,
  output logic [15:0] tx_word,
  output logic tx_word_valid,
  input wire logic tx_word_ready,
  input wire logic [15:0] rx_word,
  input wire logic rx_word_valid,
  input wire logic link_health_indication,
  output int rx_count,
  output int rx_breaks
);
  logic [15:0] seq_r; // Next word to offer
  logic [15:0] last_r; // Last word taken in
  logic have_r; // Some word taken in
  // Source: offer held until taken, stall only between words
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      seq_r <= 16'h0;
      tx_word_valid <= 1'b0;
    end else if (!tx_word_valid || tx_word_ready) begin
      seq_r <= seq_r + {15'h0, tx_word_valid};
      tx_word_valid <= !stall;
    end
  end
  // Idle data is the inverse, never a stale copy
  assign tx_word = tx_word_valid ? seq_r : ~seq_r;
  // Sink: words trusted only while health is ok
  always @(posedge core_clk) begin
    if (!nrst || clr) begin
      rx_count <= 0;
      rx_breaks <= 0;
      have_r <= 1'b0;
    end else if (rx_word_valid && link_health_indication) begin
      rx_count <= rx_count + 1;
      if (have_r && rx_word !== last_r + 16'h1) begin
        rx_breaks <= rx_breaks + 1;
      end
      last_r <= rx_word;
      have_r <= 1'b1;
    end
  end
endmodule // wsf_pcs_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Framer looped back on itself, PCS model on the word side
module testbench;
  localparam int TOH = 6; // Short overhead
  localparam int POH = 2; // Path and stuff
  localparam int PAY = 8; // Payload per row
  localparam int FR = 9 * (TOH + POH + PAY); // Words per frame
  localparam int PF = 9 * PAY; // Payload words per frame
  logic core_clk = 1'b0; // Core clock
  logic nrst = 1'b0; // Reset, active low
  logic tx_enable = 1'b1; // Transmit enable
  logic rx_enable = 1'b1; // Receive enable
  logic stall = 1'b0; // Source hold-off
  logic clr = 1'b1; // Tally restart
  logic brk = 1'b0; // Corrupt the loop
  logic [15:0] tx_word, tx_group, rx_word, rx_group;
  logic tx_word_valid, tx_word_ready, tx_underrun, rx_word_valid;
  logic link_health_indication, loss_of_frame, loss_of_pointer;
  logic label_mismatch;
  int rx_count, rx_breaks;
  int num_errors = 0;
  int n_compared = 0;
  // Clock
  always #25 core_clk = ~core_clk;
  // Loopback, inverted while broken
  assign rx_group = brk ? ~tx_group : tx_group;
  wsf_framer #(.TOH_W(TOH), .POH_W(POH), .PAY_W(PAY)) dut (
    .core_clk(core_clk), .nrst(nrst), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
    .tx_group(tx_group), .tx_underrun(tx_underrun),
    .rx_group(rx_group), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .link_health_indication(link_health_indication),
    .loss_of_frame(loss_of_frame), .loss_of_pointer(loss_of_pointer),
    .label_mismatch(label_mismatch));
  wsf_pcs_model pcs (
    .core_clk(core_clk), .nrst(nrst), .stall(stall), .clr(clr),
    .tx_word(tx_word), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid),
    .link_health_indication(link_health_indication),
    .rx_count(rx_count), .rx_breaks(rx_breaks));
  // Compare helpers
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t value %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("MISMATCH %0t count %0d not %0d", $time, got, exp);
    end
  endtask
  // Bit mirror of a word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[i] = v[15 - i];
  endfunction
  // Stop at the third framing group of a frame
  task automatic sync_tx();
    logic [15:0] prev;
    prev = 16'h0;
    for (int i = 0; i < 2 * FR; i++) begin
      @(negedge core_clk);
      if (prev == 16'hf6f6 && tx_group == 16'h2828) return;
      prev = tx_group;
    end
    cmp_flag(1'b0, 1'b1);
  endtask
  // Wait for receive health, bounded
  task automatic wait_sync();
    for (int i = 0; i < 8 * FR && !link_health_indication; i++)
      @(negedge core_clk);
    cmp_flag(link_health_indication, 1'b1);
    cmp_flag(loss_of_frame, 1'b0);
  endtask
  // Quiet outputs under reset
  task automatic t_reset();
    cmp_flag(link_health_indication, 1'b0);
    cmp_flag(loss_of_frame, 1'b1);
    cmp_flag(rx_word_valid, 1'b0);
    cmp_val(tx_group, 16'h0);
    $display("test reset done");
  endtask
  // Frame layout, slot pattern, back to back frames
  task automatic t_frame();
    int rdy;
    int und;
    rdy = 0;
    und = 0;
    sync_tx();
    for (int k = 1; k <= FR; k++) begin
      @(negedge core_clk);
      rdy += tx_word_ready;
      und += tx_underrun;
      if (k == 1) cmp_val(tx_group, 16'h2828);
      if (k == TOH + POH - TOH / 3 - 2) cmp_flag(tx_word_ready, 1'b0);
      if (k == TOH + POH - TOH / 3 - 1) cmp_flag(tx_word_ready, 1'b1);
      if (k == FR - TOH / 3) cmp_val(tx_group, 16'hf6f6);
    end
    cmp_cnt(rdy, PF);
    cmp_cnt(und, 0);
    $display("test frame done");
  endtask
  // Same slot in two frames: key cancels, mirrored words remain
  task automatic t_order();
    logic [15:0] w[2];
    logic [15:0] g[2];
    for (int f = 0; f < 2; f++) begin
      sync_tx();
      for (int i = 0; i < FR && !(tx_word_ready && tx_word_valid); i++)
        @(negedge core_clk);
      w[f] = tx_word;
      @(negedge core_clk);
      g[f] = tx_group;
    end
    cmp_val(g[0] ^ g[1], rev16(w[0] ^ w[1]));
    cmp_val(w[1] - w[0], PF[15:0]);
    $display("test order done");
  endtask
  // Loopback: sync, then two frames of unbroken words
  task automatic t_loop();
    wait_sync();
    cmp_flag(loss_of_pointer, 1'b0);
    cmp_flag(label_mismatch, 1'b0);
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
    repeat (2 * FR) @(posedge core_clk);
    @(negedge core_clk);
    cmp_cnt(rx_count, 2 * PF);
    cmp_cnt(rx_breaks, 0);
    $display("test loop done");
  endtask
  // Source stalls one frame: each slot pulses underrun
  task automatic t_under();
    int rdy;
    int und;
    rdy = 0;
    und = 0;
    @(posedge core_clk) stall <= 1'b1;
    @(negedge core_clk);
    for (int i = 0; i < FR && tx_word_valid; i++) @(negedge core_clk);
    for (int i = 0; i < FR; i++) begin
      rdy += tx_word_ready;
      @(negedge core_clk);
      und += tx_underrun;
    end
    cmp_cnt(rdy, PF);
    cmp_cnt(und, PF);
    @(posedge core_clk) stall <= 1'b0;
    $display("test underrun done");
  endtask
  // Receive off: fail health, no words
  task automatic t_rxoff();
    int n;
    n = 0;
    @(posedge core_clk) rx_enable <= 1'b0;
    repeat (2) @(negedge core_clk);
    cmp_flag(link_health_indication, 1'b0);
    repeat (FR) @(negedge core_clk) n += rx_word_valid;
    cmp_cnt(n, 0);
    @(posedge core_clk) rx_enable <= 1'b1;
    wait_sync();
    $display("test rx off done");
  endtask
  // Transmit off: no slots offered, frames go on
  task automatic t_txoff();
    int n;
    n = 0;
    @(posedge core_clk) tx_enable <= 1'b0;
    repeat (FR) @(negedge core_clk) n += tx_word_ready;
    cmp_cnt(n, 0);
    cmp_flag(loss_of_frame, 1'b0);
    @(posedge core_clk) tx_enable <= 1'b1;
    $display("test tx off done");
  endtask
  // Broken loop: frame loss and fail health, then recovery
  task automatic t_lof();
    @(posedge core_clk) brk <= 1'b1;
    for (int i = 0; i < 8 * FR && !loss_of_frame; i++)
      @(negedge core_clk);
    cmp_flag(loss_of_frame, 1'b1);
    cmp_flag(loss_of_pointer, 1'b1);
    cmp_flag(label_mismatch, 1'b1);
    @(negedge core_clk);
    cmp_flag(link_health_indication, 1'b0);
    @(posedge core_clk) brk <= 1'b0;
    wait_sync();
    $display("test frame loss done");
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    t_reset();
    @(posedge core_clk);
    nrst <= 1'b1;
    clr <= 1'b0;
    t_frame();
    t_order();
    t_loop();
    t_under();
    t_rxoff();
    t_txoff();
    t_lof();
    close_out();
  end
  // Watchdog
  initial begin
    #(50 * 140 * FR);
    num_errors++;
    close_out();
  end
endmodule // testbench
`default_nettype wire
